// >>> include/rccr_pkg.sv
`default_nettype none
package rccr_pkg;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_LOSS_FLAGS = 8'h01;
  localparam logic [7:0] ADDR_EQ_BOOST = 8'h03;
  localparam logic [7:0] ADDR_DAC_START0 = 8'h08;
  localparam logic [7:0] ADDR_OVR_EN = 8'h09;
  localparam logic [7:0] ADDR_CDR_RST = 8'h0a;
  localparam logic [7:0] ADDR_DAC_START1 = 8'h0b;
  localparam logic [7:0] ADDR_PAT_CLK = 8'h0d;
  localparam logic [7:0] ADDR_EYE_CFG = 8'h11;
  localparam logic [7:0] ADDR_BOOST_LIM = 8'h13;
  localparam logic [7:0] ADDR_SD_FORCE = 8'h14;
  localparam logic [7:0] ADDR_DEEMPH = 8'h15;
  localparam logic [7:0] ADDR_VCO_DIV = 8'h18;
  localparam logic [7:0] ADDR_MUX_PAT = 8'h1e;
  localparam logic [7:0] ADDR_POLARITY = 8'h1f;
  localparam logic [7:0] ADDR_EYE_CTL = 8'h24;
  localparam logic [7:0] ADDR_EYE_CNT_HI = 8'h25;
  localparam logic [7:0] ADDR_EYE_CNT_LO = 8'h26;
  localparam logic [7:0] ADDR_HEYE = 8'h27;
  localparam logic [7:0] ADDR_VEYE = 8'h28;
  localparam logic [7:0] ADDR_EYE_RANGE = 8'h29;
  localparam logic [7:0] ADDR_EYE_TIMER = 8'h2a;
  localparam logic [7:0] ADDR_SWING = 8'h2d;
  localparam logic [7:0] ADDR_RATE = 8'h2f;
  localparam logic [7:0] ADDR_EYE_INT_PAT = 8'h30;
  localparam logic [7:0] ADDR_ADAPT_MODE = 8'h31;
  localparam logic [7:0] ADDR_EYE_THR = 8'h32;
  localparam logic [7:0] ADDR_EYE_INT_EN = 8'h36;
  // Writable-bit masks per register; other bits read zero, except bit 4 of 0x30, which reads the eye interrupt flag.
  localparam logic [7:0] MASK_SOFT_RESET = 8'h04;
  localparam logic [7:0] MASK_EQ_BOOST = 8'hff;
  localparam logic [7:0] MASK_DAC = 8'h1f;
  localparam logic [7:0] MASK_OVR_EN = 8'ha4;
  localparam logic [7:0] MASK_CDR_RST = 8'h0c;
  localparam logic [7:0] MASK_PAT_CLK = 8'h20;
  localparam logic [7:0] MASK_EYE_CFG = 8'he0;
  localparam logic [7:0] MASK_BOOST_LIM = 8'h04;
  localparam logic [7:0] MASK_SD_FORCE = 8'hc0;
  localparam logic [7:0] MASK_DEEMPH = 8'h47;
  localparam logic [7:0] MASK_VCO_DIV = 8'h74;
  localparam logic [7:0] MASK_MUX_PAT = 8'hf0;
  localparam logic [7:0] MASK_POLARITY = 8'h80;
  localparam logic [7:0] MASK_EYE_CTL = 8'h81;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_SWING = 8'h07;
  localparam logic [7:0] MASK_EYE_PAT = 8'h0b;
  localparam logic [7:0] MASK_ADAPT = 8'h78;
  localparam logic [7:0] MASK_EYE_INT_EN = 8'h40;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DAC_START1 = 8'h0f;
  localparam logic [7:0] RST_EYE_CFG = 8'h20;
  localparam logic [7:0] RST_VCO_DIV = 8'h40;
  localparam logic [7:0] RST_MUX_PAT = 8'he0;
  localparam logic [7:0] RST_EYE_TIMER = 8'h30;
  localparam logic [7:0] RST_RATE = 8'h06;
  localparam logic [7:0] RST_ADAPT = 8'h20;
  localparam logic [7:0] RST_EYE_THR = 8'h11;
  // Field positions.
  localparam int BIT_SOFT_RESET = 2;
  localparam int BIT_LOCK_LOSS = 4;
  localparam int BIT_DETECT_LOSS = 0;
  localparam int BIT_DAC_OVR = 7;
  localparam int BIT_MUX_OVR = 5;
  localparam int BIT_DIV_OVR = 2;
  localparam int BIT_RST_OVR = 3;
  localparam int BIT_RST_VAL = 2;
  localparam int BIT_PAT_CLK = 5;
  localparam int BIT_EYE_PD = 5;
  localparam int BIT_BOOST_LIM = 2;
  localparam int BIT_FORCE_ON = 7;
  localparam int BIT_FORCE_OFF = 6;
  localparam int BIT_DEEMPH_RANGE = 6;
  localparam int BIT_PAT_EN = 4;
  localparam int BIT_POLARITY = 7;
  localparam int BIT_FAST_EYE = 7;
  localparam int BIT_EYE_START = 0;
  localparam int BIT_ADAPT_IDX = 3;
  localparam int BIT_PPM_CHECK = 2;
  localparam int BIT_FLD_DISABLE = 1;
  localparam int BIT_ADAPT_START = 0;
  localparam int BIT_EYE_INT = 4;
  localparam int BIT_PAT_DIG = 3;
  localparam int BIT_EYE_INT_EN = 6;
  localparam int NUM_REGS = 22;
endpackage
`default_nettype wire

// >>> design/rccr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rccr_regs
  import rccr_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register access from the selected-channel decoder
  input wire logic i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Status from the analog and recovery logic
  input wire logic i_lock_lost,
  input wire logic i_detect_lost,
  input wire logic i_raw_detect,
  input wire logic i_eye_done,
  input wire logic [15:0] i_eye_count,
  input wire logic [7:0] i_heye,
  input wire logic [7:0] i_veye,
  // Equalizer
  output logic [1:0] o_boost_stage_zero,
  output logic [1:0] o_boost_stage_one,
  output logic [1:0] o_boost_stage_two,
  output logic [2:0] o_boost_stage_three,
  output logic o_adapt_start,
  output logic [1:0] o_adapt_mode,
  output logic [1:0] o_merit_type,
  output logic o_adapt_index_override,
  // Clock recovery
  output logic o_vco_dac_override_enable,
  output logic [4:0] o_vco_dac_start_value_zero,
  output logic [4:0] o_vco_dac_start_value_one,
  output logic o_output_mux_override_enable,
  output logic [2:0] o_output_mux_sel,
  output logic o_divider_override_enable,
  output logic [2:0] o_vco_div_ratio,
  output logic o_recovery_reset,
  output logic [1:0] o_rate,
  output logic [1:0] o_subrate,
  output logic o_ppm_check_en,
  output logic o_false_lock_disable,
  // Signal detect
  output logic o_signal_detect,
  // Driver
  output logic o_polarity_invert,
  output logic [2:0] o_deemphasis,
  output logic o_deemphasis_range,
  output logic [2:0] o_swing,
  output logic o_slow_edges,
  // Pattern generator
  output logic o_pattern_enable,
  output logic o_pattern_clock_enable,
  output logic o_pattern_digital_enable,
  output logic [1:0] o_pattern_select,
  // Eye monitor
  output logic o_eye_monitor_powerdown,
  output logic [1:0] o_eye_vrange,
  output logic o_eye_start,
  output logic o_fast_eye,
  output logic [7:0] o_eye_timer_threshold,
  output logic o_eye_interrupt
);

  // ==========================================================================
  // Register table
  // ==========================================================================
  localparam logic [7:0] ADDR_TBL [NUM_REGS] = '{
    ADDR_EQ_BOOST, ADDR_DAC_START0, ADDR_OVR_EN, ADDR_CDR_RST, ADDR_DAC_START1,
    ADDR_PAT_CLK, ADDR_EYE_CFG, ADDR_BOOST_LIM, ADDR_SD_FORCE, ADDR_DEEMPH,
    ADDR_VCO_DIV, ADDR_MUX_PAT, ADDR_POLARITY, ADDR_EYE_CTL, ADDR_EYE_TIMER,
    ADDR_SWING, ADDR_RATE, ADDR_EYE_INT_PAT, ADDR_ADAPT_MODE, ADDR_EYE_THR,
    ADDR_EYE_INT_EN, ADDR_SOFT_RESET};
  localparam logic [7:0] MASK_TBL [NUM_REGS] = '{
    MASK_EQ_BOOST, MASK_DAC, MASK_OVR_EN, MASK_CDR_RST, MASK_DAC,
    MASK_PAT_CLK, MASK_EYE_CFG, MASK_BOOST_LIM, MASK_SD_FORCE, MASK_DEEMPH,
    MASK_VCO_DIV, MASK_MUX_PAT, MASK_POLARITY, MASK_EYE_CTL, MASK_FULL,
    MASK_SWING, MASK_FULL, MASK_EYE_PAT, MASK_ADAPT, MASK_FULL,
    MASK_EYE_INT_EN, MASK_SOFT_RESET};
  localparam logic [7:0] RST_TBL [NUM_REGS] = '{
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_DAC_START1,
    RST_ZERO, RST_EYE_CFG, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_VCO_DIV, RST_MUX_PAT, RST_ZERO, RST_ZERO, RST_EYE_TIMER,
    RST_ZERO, RST_RATE, RST_ZERO, RST_ADAPT, RST_EYE_THR,
    RST_ZERO, RST_ZERO};
  localparam int IX_BOOST = 0;
  localparam int IX_DAC0 = 1;
  localparam int IX_OVR = 2;
  localparam int IX_CDR = 3;
  localparam int IX_DAC1 = 4;
  localparam int IX_PATCLK = 5;
  localparam int IX_EYECFG = 6;
  localparam int IX_LIM = 7;
  localparam int IX_SD = 8;
  localparam int IX_DEEMPH = 9;
  localparam int IX_DIV = 10;
  localparam int IX_MUX = 11;
  localparam int IX_POL = 12;
  localparam int IX_EYECTL = 13;
  localparam int IX_TIMER = 14;
  localparam int IX_SWING = 15;
  localparam int IX_RATE = 16;
  localparam int IX_PAT = 17;
  localparam int IX_ADAPT = 18;
  localparam int IX_THR = 19;
  localparam int IX_INTEN = 20;
  localparam int IX_SOFT = 21;

  logic [7:0] regs_r [NUM_REGS];
  logic [NUM_REGS-1:0] hit;
  logic soft_reset;
  logic lock_loss_r;
  logic detect_loss_r;
  logic eye_int_r;
  logic [15:0] eye_count_r;
  logic [7:0] heye_r;
  logic [7:0] veye_r;
  logic [7:0] rd_table;
  logic [7:0] rd_status;
  logic eye_below;

  // ==========================================================================
  // Writable registers
  // ==========================================================================
  // A soft reset is itself a register write, so the whole set returns to
  // defaults on the following edge and the trigger bit reads back as zero.
  assign soft_reset = i_wr_en && (i_addr == ADDR_SOFT_RESET) && i_wdata[BIT_SOFT_RESET];

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_reg
      assign hit[g] = (i_addr == ADDR_TBL[g]);
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_n || soft_reset)
          regs_r[g] <= RST_TBL[g];
        else if (i_wr_en && hit[g])
          regs_r[g] <= i_wdata & MASK_TBL[g];
        else if (g == IX_EYECTL)
          regs_r[g] <= regs_r[g] & ~(8'h01 << BIT_EYE_START);
        else if (g == IX_SOFT)
          regs_r[g] <= RST_ZERO;
      end
    end
  endgenerate

  // ==========================================================================
  // Status captured from the channel
  // ==========================================================================
  // The eye threshold compares only the upper nibble of each 8-bit opening.
  assign eye_below = regs_r[IX_INTEN][BIT_EYE_INT_EN] &&
                     ((i_heye[7:4] < regs_r[IX_THR][7:4]) ||
                      (i_veye[7:4] < regs_r[IX_THR][3:0]));

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || soft_reset)
    begin
      lock_loss_r <= 1'b0;
      detect_loss_r <= 1'b0;
      eye_int_r <= 1'b0;
      eye_count_r <= 16'h0000;
      heye_r <= 8'h00;
      veye_r <= 8'h00;
    end
    else
    begin
      lock_loss_r <= i_lock_lost;
      detect_loss_r <= i_detect_lost;
      eye_int_r <= eye_below;
      heye_r <= i_heye;
      veye_r <= i_veye;
      if (i_eye_done)
        eye_count_r <= i_eye_count;
    end
  end

  // ==========================================================================
  // Read-back
  // ==========================================================================
  always_comb
  begin
    rd_table = 8'h00;
    for (int k = 0; k < NUM_REGS; k++)
      if (hit[k])
        rd_table = regs_r[k];
  end

  always_comb
  begin
    case (i_addr)
      ADDR_LOSS_FLAGS: rd_status = {3'h0, lock_loss_r, 3'h0, detect_loss_r};
      ADDR_EYE_CNT_HI: rd_status = eye_count_r[15:8];
      ADDR_EYE_CNT_LO: rd_status = eye_count_r[7:0];
      ADDR_HEYE: rd_status = heye_r;
      ADDR_VEYE: rd_status = veye_r;
      ADDR_EYE_RANGE: rd_status = {1'b0, regs_r[IX_EYECFG][7:6], 5'h00};
      ADDR_EYE_INT_PAT: rd_status = regs_r[IX_PAT] | ({7'h00, eye_int_r} << BIT_EYE_INT);
      default: rd_status = rd_table;
    endcase
  end

  assign o_rdata = rd_status;

  // ==========================================================================
  // Control outputs
  // ==========================================================================
  assign o_boost_stage_zero = regs_r[IX_BOOST][7:6];
  assign o_boost_stage_one = regs_r[IX_BOOST][5:4];
  assign o_boost_stage_two = regs_r[IX_BOOST][3:2];
  assign o_boost_stage_three = {regs_r[IX_LIM][BIT_BOOST_LIM], regs_r[IX_BOOST][1:0]};
  assign o_vco_dac_override_enable = regs_r[IX_OVR][BIT_DAC_OVR];
  // Gated values stay zero while their override is off, so the analog side
  // cannot pick up a stale setting by accident.
  assign o_vco_dac_start_value_zero = o_vco_dac_override_enable ? regs_r[IX_DAC0][4:0] : 5'h00;
  assign o_vco_dac_start_value_one = o_vco_dac_override_enable ? regs_r[IX_DAC1][4:0] : 5'h00;
  assign o_output_mux_override_enable = regs_r[IX_OVR][BIT_MUX_OVR];
  assign o_output_mux_sel = o_output_mux_override_enable ? regs_r[IX_MUX][7:5] : 3'h0;
  assign o_divider_override_enable = regs_r[IX_OVR][BIT_DIV_OVR];
  assign o_vco_div_ratio = o_divider_override_enable ? regs_r[IX_DIV][6:4] : 3'h0;
  assign o_slow_edges = regs_r[IX_DIV][BIT_DIV_OVR];
  assign o_recovery_reset = regs_r[IX_CDR][BIT_RST_OVR] && regs_r[IX_CDR][BIT_RST_VAL];
  assign o_signal_detect = regs_r[IX_SD][BIT_FORCE_ON] ||
                           (!regs_r[IX_SD][BIT_FORCE_OFF] && i_raw_detect);
  assign o_pattern_enable = regs_r[IX_MUX][BIT_PAT_EN];
  assign o_pattern_clock_enable = regs_r[IX_PATCLK][BIT_PAT_CLK];
  assign o_pattern_digital_enable = regs_r[IX_PAT][BIT_PAT_DIG];
  assign o_pattern_select = regs_r[IX_PAT][1:0];
  assign o_polarity_invert = regs_r[IX_POL][BIT_POLARITY];
  assign o_deemphasis = regs_r[IX_DEEMPH][2:0];
  assign o_deemphasis_range = regs_r[IX_DEEMPH][BIT_DEEMPH_RANGE];
  assign o_swing = regs_r[IX_SWING][2:0];
  assign o_eye_start = regs_r[IX_EYECTL][BIT_EYE_START];
  assign o_eye_monitor_powerdown = regs_r[IX_EYECFG][BIT_EYE_PD];
  assign o_eye_vrange = regs_r[IX_EYECFG][7:6];
  assign o_eye_timer_threshold = regs_r[IX_TIMER];
  assign o_fast_eye = regs_r[IX_EYECTL][BIT_FAST_EYE];
  assign o_rate = regs_r[IX_RATE][7:6];
  assign o_subrate = regs_r[IX_RATE][5:4];
  assign o_adapt_index_override = regs_r[IX_RATE][BIT_ADAPT_IDX];
  assign o_ppm_check_en = regs_r[IX_RATE][BIT_PPM_CHECK];
  assign o_false_lock_disable = regs_r[IX_RATE][BIT_FLD_DISABLE];
  assign o_adapt_start = regs_r[IX_RATE][BIT_ADAPT_START];
  assign o_adapt_mode = regs_r[IX_ADAPT][6:5];
  assign o_merit_type = regs_r[IX_ADAPT][4:3];
  assign o_eye_interrupt = eye_int_r;

endmodule
`default_nettype wire

// >>> testbench/rccr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Port-level checks of the channel register bank.
module rccr_regs_chk (
  // Clock, reset and register access
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  // Observed controls
  input wire logic o_eye_start,
  input wire logic o_signal_detect,
  input wire logic o_polarity_invert,
  input wire logic o_output_mux_override_enable,
  input wire logic [2:0] o_output_mux_sel,
  input wire logic o_divider_override_enable,
  input wire logic [2:0] o_vco_div_ratio,
  input wire logic o_recovery_reset,
  input wire logic [7:0] o_eye_timer_threshold,
  input wire logic o_eye_monitor_powerdown,
  input wire logic o_false_lock_disable
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  soft_reset_a: assert property (
    i_wr_en && i_addr == 8'h00 && i_wdata[2] |=> o_eye_timer_threshold == 8'h30)
    else $error("soft reset did not restore timer threshold");
  eye_start_a: assert property (
    i_wr_en && i_addr == 8'h24 && i_wdata[0] |=> o_eye_start ##1 !o_eye_start)
    else $error("eye start is not a single cycle pulse");
  force_on_a: assert property (
    i_wr_en && i_addr == 8'h14 && i_wdata[7] |=> o_signal_detect)
    else $error("forced detect on not seen");
  out_polarity_a: assert property (
    i_wr_en && i_addr == 8'h1f |=> o_polarity_invert == $past(i_wdata[7]))
    else $error("polarity does not follow write");
  mux_gate_a: assert property (
    !o_output_mux_override_enable |-> o_output_mux_sel == 3'h0)
    else $error("mux select leaks without override");
  div_gate_a: assert property (
    !o_divider_override_enable |-> o_vco_div_ratio == 3'h0)
    else $error("divider ratio leaks without override");
  recovery_reset_a: assert property (
    i_wr_en && i_addr == 8'h0a |=> o_recovery_reset == ($past(i_wdata[3]) && $past(i_wdata[2])))
    else $error("recovery reset does not follow override");
  reset_defaults_a: assert property (disable iff (1'b0)
    !i_rst_n |=> o_eye_monitor_powerdown && o_false_lock_disable && o_eye_timer_threshold == 8'h30)
    else $error("power-up defaults wrong");
endmodule
bind rccr_regs rccr_regs_chk u_chk (.*);
`default_nettype wire

// >>> testbench/rccr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Management host model; channel selection is done before these accesses.
module rccr_host (
  // Clock
  input wire logic i_mclk,
  // Register access
  output logic o_wr_en,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_wr_en = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    o_wr_en = 1'b0;
    // Released data is scrambled so nothing relies on a stale value.
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    #1;
    o_rd = 1'b1;
    o_addr = a;
    @(posedge i_mclk);
    #1;
    o_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/rccr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rccr_regs_tb;
  logic i_mclk = 0, i_rst_n = 0, i_wr_en, rd_on, i_lock_lost = 0, i_detect_lost = 0, i_raw_detect = 0, i_eye_done = 0;
  logic [7:0] i_addr, i_wdata, i_heye = 0, i_veye = 0, o_rdata, o_eye_timer_threshold;
  logic [15:0] i_eye_count = 0, lq, q[$];
  logic o_adapt_start, o_adapt_index_override, o_vco_dac_override_enable, o_output_mux_override_enable;
  logic o_divider_override_enable, o_recovery_reset, o_ppm_check_en, o_false_lock_disable, o_signal_detect;
  logic o_polarity_invert, o_deemphasis_range, o_slow_edges, o_pattern_enable, o_pattern_clock_enable;
  logic o_pattern_digital_enable, o_eye_monitor_powerdown, o_eye_start, o_fast_eye, o_eye_interrupt;
  logic [1:0] o_boost_stage_zero, o_boost_stage_one, o_boost_stage_two, o_adapt_mode, o_merit_type;
  logic [1:0] o_rate, o_subrate, o_pattern_select, o_eye_vrange;
  logic [2:0] o_boost_stage_three, o_output_mux_sel, o_vco_div_ratio, o_deemphasis, o_swing;
  logic [4:0] o_vco_dac_start_value_zero, o_vco_dac_start_value_one;
  logic [7:0] v[256];
  logic [7:0] al[31] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h11, 8'h13, 8'h14,
    8'h15, 8'h18, 8'h1e, 8'h1f, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2d, 8'h2f, 8'h30, 8'h31,
    8'h32, 8'h36, 8'h40, 8'hff};
  int bad_count, cmp_count;
  rccr_regs dut (.*);
  rccr_host h (.i_mclk(i_mclk), .o_wr_en(i_wr_en), .o_rd(rd_on), .o_addr(i_addr), .o_wdata(i_wdata));
  always #50 i_mclk = ~i_mclk;
  function automatic logic [7:0] dv(logic [7:0] a);
    case (a)
      8'h0b: return 8'h0f;
      8'h11, 8'h31: return 8'h20;
      8'h18: return 8'h40;
      8'h1e: return 8'he0;
      8'h2a: return 8'h30;
      8'h2f: return 8'h06;
      8'h32: return 8'h11;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] wm(logic [7:0] a);
    case (a)
      8'h03, 8'h2a, 8'h2f, 8'h32: return 8'hff;
      8'h08, 8'h0b: return 8'h1f;
      8'h09: return 8'ha4;
      8'h0a: return 8'h0c;
      8'h0d: return 8'h20;
      8'h11: return 8'he0;
      8'h13: return 8'h04;
      8'h14: return 8'hc0;
      8'h15: return 8'h47;
      8'h18: return 8'h74;
      8'h1e: return 8'hf0;
      8'h1f, 8'h24: return 8'h80;
      8'h2d: return 8'h07;
      8'h30: return 8'h0b;
      8'h31: return 8'h78;
      8'h36: return 8'h40;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    q.push_back({a, e});
    h.rd(a);
  endtask
  task automatic defs();
    foreach (al[i]) rd(al[i], dv(al[i]));
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ========
  // Read monitor: each sampled read is matched against the oldest note.
  always @(posedge i_mclk)
    if (rd_on === 1'b1)
    begin
      lq = q.pop_front();
      chk($sformatf("reg %h", lq[15:8]), 16'(o_rdata), 16'(lq[7:0]));
    end
  initial
  begin
    repeat (6000) @(posedge i_mclk);
    bad_count++;
    summarize();
  end
  // ========
  // Main sequence.
  initial
  begin
    void'($urandom(32'h6a9faaf3));
    repeat (20) @(posedge i_mclk);
    #1;
    i_rst_n = 1;
    defs();
    $display("reset values done");
    i_heye = 8'hff;
    i_veye = 8'hff;
    foreach (al[i])
      if (al[i] != 8'h00)
      begin
        v[al[i]] = 8'($urandom);
        h.wr(al[i], v[al[i]]);
      end
    foreach (al[i])
      if (al[i] != 8'h00)
        rd(al[i], (al[i] == 8'h27 || al[i] == 8'h28) ? 8'hff :
          (al[i] == 8'h29) ? {1'b0, v[8'h11][7:6], 5'h00} : v[al[i]] & wm(al[i]));
    chk("stage3", 16'(o_boost_stage_three), 16'({v[8'h13][2], v[8'h03][1:0]}));
    chk("boost", 16'({o_boost_stage_zero, o_boost_stage_one, o_boost_stage_two}), 16'(v[8'h03][7:2]));
    chk("polarity", 16'(o_polarity_invert), 16'(v[8'h1f][7]));
    chk("driver", 16'({o_deemphasis_range, o_deemphasis, o_swing}), 16'({v[8'h15][6], v[8'h15][2:0], v[8'h2d][2:0]}));
    chk("pattern", 16'({o_pattern_enable, o_pattern_clock_enable, o_pattern_digital_enable, o_pattern_select}),
      16'({v[8'h1e][4], v[8'h0d][5], v[8'h30][3], v[8'h30][1:0]}));
    chk("rate", 16'({o_rate, o_subrate, o_adapt_index_override, o_ppm_check_en, o_false_lock_disable,
      o_adapt_start}), 16'(v[8'h2f]));
    chk("adapt", 16'({o_adapt_mode, o_merit_type}), 16'(v[8'h31][6:3]));
    chk("eye", 16'({o_eye_vrange, o_eye_monitor_powerdown, o_fast_eye, o_eye_timer_threshold}),
      16'({v[8'h11][7:5], v[8'h24][7], v[8'h2a]}));
    $display("read write done");
    h.wr(8'h09, 8'h00);
    chk("gated", 16'({o_output_mux_sel, o_vco_div_ratio, o_vco_dac_start_value_zero,
      o_vco_dac_start_value_one}), 16'h0000);
    h.wr(8'h09, 8'ha4);
    chk("ovr", 16'({o_vco_dac_override_enable, o_output_mux_override_enable, o_divider_override_enable}), 16'h0007);
    chk("mux", 16'({o_output_mux_sel, o_vco_div_ratio, o_slow_edges}),
      16'({v[8'h1e][7:5], v[8'h18][6:4], v[8'h18][2]}));
    chk("dac", 16'({o_vco_dac_start_value_zero, o_vco_dac_start_value_one}), 16'({v[8'h08][4:0], v[8'h0b][4:0]}));
    h.wr(8'h0a, 8'h0c);
    chk("crst", 16'(o_recovery_reset), 16'h0001);
    i_raw_detect = 1;
    h.wr(8'h14, 8'h40);
    chk("sd_off", 16'(o_signal_detect), 16'h0000);
    h.wr(8'h14, 8'hc0);
    chk("sd_on", 16'(o_signal_detect), 16'h0001);
    h.wr(8'h14, 8'h00);
    chk("sd_pass", 16'(o_signal_detect), 16'h0001);
    i_raw_detect = 0;
    #1;
    chk("sd_idle", 16'(o_signal_detect), 16'h0000);
    $display("overrides done");
    h.wr(8'h24, 8'h01);
    chk("start", 16'(o_eye_start), 16'h0001);
    i_eye_count = 16'($urandom);
    i_eye_done = 1;
    @(posedge i_mclk);
    #1;
    i_eye_done = 0;
    chk("start", 16'(o_eye_start), 16'h0000);
    rd(8'h25, i_eye_count[15:8]);
    rd(8'h26, i_eye_count[7:0]);
    i_lock_lost = 1;
    i_detect_lost = 1;
    i_heye = 8'h10;
    h.wr(8'h32, 8'h11);
    h.wr(8'h36, 8'h40);
    @(posedge i_mclk);
    #1;
    chk("eint_edge", 16'(o_eye_interrupt), 16'h0000);
    i_heye = 8'h0f;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("eint", 16'(o_eye_interrupt), 16'h0001);
    rd(8'h30, 8'h10 | (v[8'h30] & 8'h0b));
    rd(8'h01, 8'h11);
    i_heye = 8'hff;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("eint_clear", 16'(o_eye_interrupt), 16'h0000);
    i_veye = 8'h0f;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("eint_vert", 16'(o_eye_interrupt), 16'h0001);
    $display("status done");
    i_lock_lost = 0;
    i_detect_lost = 0;
    i_heye = 8'h00;
    i_veye = 8'h00;
    h.wr(8'h00, 8'h04);
    defs();
    $display("soft reset done");
    summarize();
  end
endmodule
`default_nettype wire
